// file: inc/dtc_pkg.sv
// dual timer/counter: register map, field layout, reset values and state type
// assumes byte addressing on apb; register index times four gives the byte address
package dtc_pkg;

	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [7:0] IDX_RUN_CTRL = 8'h88;
	localparam logic [7:0] IDX_MODE_SEL = 8'h89;
	localparam logic [7:0] IDX_T0_LOW = 8'h8a;
	localparam logic [7:0] IDX_T1_LOW = 8'h8b;
	localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
	localparam logic [7:0] IDX_T1_HIGH = 8'h8d;
	localparam logic [7:0] IDX_CLK_CTRL = 8'h8e;
	localparam logic [7:0] IDX_IRQ_STS = 8'h80;
	localparam logic [7:0] IDX_IRQ_MSK = 8'h81;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MS_GATE1 = 7;
	localparam int MS_SRC1 = 6;
	localparam int MS_MODE1_HI = 5;
	localparam int MS_MODE1_LO = 4;
	localparam int MS_GATE0 = 3;
	localparam int MS_SRC0 = 2;
	localparam int MS_MODE0_HI = 1;
	localparam int MS_MODE0_LO = 0;
	localparam int CK_T1_DIRECT = 4;
	localparam int CK_T0_DIRECT = 3;
	localparam logic [7:0] CK_WMASK = 8'h18;
	localparam int RC_T1_FLAG = 7;
	localparam int RC_T1_RUN = 6;
	localparam int RC_T0_FLAG = 5;
	localparam int RC_T0_RUN = 4;
	localparam int IRQ_T0 = 0;
	localparam int IRQ_T1 = 1;
	localparam int LO13_W = 5;

	// ----------------------------------------------------------------
	// modes, reset values, timing
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_13 = 2'h0;
	localparam logic [1:0] MODE_16 = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int PRESC_DIV = 12;
	localparam int PRESC_W = 4;

	typedef struct packed {
		logic [2:0] sy_ext_irq0_pin;
		logic [2:0] sy_ext_irq1_pin;
		logic [2:0] sy_cnt0;
		logic [2:0] sy_cnt1;
		logic [PRESC_W-1:0] presc;
		logic [7:0] timer_mode_reg;
		logic [7:0] timer_clock_ctrl_reg;
		logic [7:0] t0_count_low;
		logic [7:0] t0_count_high;
		logic [7:0] t1_count_low;
		logic [7:0] t1_count_high;
		logic t0_run_bit;
		logic t1_run_bit;
		logic t0_overflow_flag;
		logic t1_overflow_flag;
		logic [1:0] irq_sts;
		logic [1:0] irq_msk;
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} dtc_state_t;

endpackage : dtc_pkg

// file: core/dtc_top.sv
// dual timer/counter with apb register access and one level interrupt
// assumes one clock; count and gate pins are asynchronous board inputs
//
// Behaviour
// - timer 1 counts when run set and, if gated, ext irq1 pin high.
// - timer 0 counts when run set and, if gated, ext irq0 pin high.
// - timer 1 select bit picks prescaled clock or falling edges of count pin.
// - timer 0 select bit picks prescaled clock or falling edges of count pin.
// - mode 00 is a 13-bit counter, mode 01 a 16-bit counter.
// - timer 1 mode 10: 8-bit low byte reloaded from high byte.
// - timer 0 mode 10: 8-bit low byte reloaded from high byte.
// - timer 1 mode 11 halts timer 1.
// - timer 0 mode 11 splits into two independent 8-bit units.
// - timer 0 count is two rw bytes, reset to zero.
// - timer 1 count is two rw bytes, reset to zero.
// - timer 1 clock mode bit: 0 divides clock by 12, 1 direct.
// - timer 0 clock mode bit: 0 divides clock by 12, 1 direct.
// - mode and clock control registers reset to zero.
// - clearing run bit halts a timer and keeps its count.
// - overflow sets flag; service entry clears it; software may set or clear.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none

module dtc_top #(
	parameter int PRESC_DIV = dtc_pkg::PRESC_DIV
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [dtc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [dtc_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic ext_irq0_pin_i,
	input wire logic ext_irq1_pin_i,
	input wire logic t0_count_pin_i,
	input wire logic t1_count_pin_i,
	input wire logic t0_isr_ack_i,
	input wire logic t1_isr_ack_i,
	output logic [dtc_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o
);

	// the prescaler counter is PRESC_W bits wide: a divider above its range would wrap
	localparam logic [dtc_pkg::PRESC_W-1:0] PRESC_LAST = dtc_pkg::PRESC_W'(PRESC_DIV - 1);

	dtc_pkg::dtc_state_t s_r;
	dtc_pkg::dtc_state_t s_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// byte address of a register from its index
	function automatic logic [dtc_pkg::ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = dtc_pkg::ADDR_W'({idx, 2'h0});
	endfunction : reg_addr

	// 8-bit increment with carry out, shared by both halves of split mode
	function automatic logic [8:0] dtc_inc8(input logic [7:0] v);
		dtc_inc8 = {1'b0, v} + 9'h001;
	endfunction : dtc_inc8

	// falling edge seen between synchroniser stages two and three
	function automatic logic dtc_fall(input logic [2:0] sy);
		dtc_fall = sy[2] & ~sy[1];
	endfunction : dtc_fall

	// one increment in the given mode; returns {overflow, high, low}
	function automatic logic [16:0] dtc_step(input logic [1:0] md, input logic [7:0] hi,
		input logic [7:0] lo);
		logic [13:0] c13;
		logic [16:0] c16;
		logic [8:0] c8;
		c13 = {1'b0, hi, lo[dtc_pkg::LO13_W-1:0]} + 14'h0001;
		c16 = {1'b0, hi, lo} + 17'h00001;
		c8 = dtc_inc8(lo);
		case (md)
			dtc_pkg::MODE_13: begin
				// upper low-byte bits are left alone in 13-bit mode
				dtc_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
			end
			dtc_pkg::MODE_16: begin
				dtc_step = c16;
			end
			dtc_pkg::MODE_RELOAD: begin
				dtc_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
			end
			default: begin
				dtc_step = {1'b0, hi, lo};
			end
		endcase
	endfunction : dtc_step

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic tick12;
	logic lvl_ext_irq0_pin;
	logic lvl_ext_irq1_pin;
	logic fall_cnt0;
	logic fall_cnt1;
	logic clk0_tick;
	logic clk1_tick;
	logic src0;
	logic src1;
	logic run0;
	logic run1;
	logic ovf0;
	logic ovf1;
	logic c1;
	logic [8:0] sum;
	logic [16:0] stp;
	logic setup;
	logic wr;
	logic [7:0] wd;
	logic hit;
	logic [7:0] rd;

	always_comb begin
		s_nxt = s_r;
		c1 = 1'b0;
		sum = '0;
		stp = '0;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		// first stage feeds only the second; edges come from stages two and three
		s_nxt.sy_ext_irq0_pin = {s_r.sy_ext_irq0_pin[1:0], ext_irq0_pin_i};
		s_nxt.sy_ext_irq1_pin = {s_r.sy_ext_irq1_pin[1:0], ext_irq1_pin_i};
		s_nxt.sy_cnt0 = {s_r.sy_cnt0[1:0], t0_count_pin_i};
		s_nxt.sy_cnt1 = {s_r.sy_cnt1[1:0], t1_count_pin_i};
		lvl_ext_irq0_pin = s_r.sy_ext_irq0_pin[1];
		lvl_ext_irq1_pin = s_r.sy_ext_irq1_pin[1];
		fall_cnt0 = dtc_fall(s_r.sy_cnt0);
		fall_cnt1 = dtc_fall(s_r.sy_cnt1);

		// ----------------------------------------------------------------
		// clock paths and run qualification
		// ----------------------------------------------------------------

		// shared divide-by-twelve prescaler, free running
		tick12 = (s_r.presc == PRESC_LAST);
		s_nxt.presc = tick12 ? '0 : s_r.presc + 1'b1;
		clk0_tick = s_r.timer_clock_ctrl_reg[dtc_pkg::CK_T0_DIRECT] | tick12;
		clk1_tick = s_r.timer_clock_ctrl_reg[dtc_pkg::CK_T1_DIRECT] | tick12;
		src0 = s_r.timer_mode_reg[dtc_pkg::MS_SRC0] ? fall_cnt0 : clk0_tick;
		src1 = s_r.timer_mode_reg[dtc_pkg::MS_SRC1] ? fall_cnt1 : clk1_tick;
		run0 = s_r.t0_run_bit & (~s_r.timer_mode_reg[dtc_pkg::MS_GATE0] | lvl_ext_irq0_pin);
		run1 = s_r.t1_run_bit & (~s_r.timer_mode_reg[dtc_pkg::MS_GATE1] | lvl_ext_irq1_pin);

		// ----------------------------------------------------------------
		// timer 0
		// ----------------------------------------------------------------
		if (s_r.timer_mode_reg[dtc_pkg::MS_MODE0_HI:dtc_pkg::MS_MODE0_LO] ==
			dtc_pkg::MODE_SPLIT) begin
			if (run0 && src0) begin
				sum = dtc_inc8(s_r.t0_count_low);
				{ovf0, s_nxt.t0_count_low} = sum;
			end
			// high half is a plain timer: no gate, no pin, timer 1 run bit
			if (s_r.t1_run_bit && clk0_tick) begin
				sum = dtc_inc8(s_r.t0_count_high);
				{ovf1, s_nxt.t0_count_high} = sum;
			end
		end else if (run0 && src0) begin
			stp = dtc_step(s_r.timer_mode_reg[dtc_pkg::MS_MODE0_HI:dtc_pkg::MS_MODE0_LO],
				s_r.t0_count_high, s_r.t0_count_low);
			{ovf0, s_nxt.t0_count_high, s_nxt.t0_count_low} = stp;
		end

		// ----------------------------------------------------------------
		// timer 1
		// ----------------------------------------------------------------
		if (run1 && src1 &&
			s_r.timer_mode_reg[dtc_pkg::MS_MODE1_HI:dtc_pkg::MS_MODE1_LO] !=
			dtc_pkg::MODE_SPLIT) begin
			stp = dtc_step(s_r.timer_mode_reg[dtc_pkg::MS_MODE1_HI:dtc_pkg::MS_MODE1_LO],
				s_r.t1_count_high, s_r.t1_count_low);
			{c1, s_nxt.t1_count_high, s_nxt.t1_count_low} = stp;
			// while timer 0 is split its high half owns timer 1's flag
			if (s_r.timer_mode_reg[dtc_pkg::MS_MODE0_HI:dtc_pkg::MS_MODE0_LO] !=
				dtc_pkg::MODE_SPLIT) begin
				ovf1 = c1;
			end
		end

		// ----------------------------------------------------------------
		// apb: setup cycle prepares the answer, access cycle commits writes
		// ----------------------------------------------------------------
		setup = psel_i & ~penable_i;
		wr = psel_i & penable_i & s_r.pready & pwrite_i & pstrb_i[0];
		wd = pwdata_i[7:0];
		hit = 1'b1;
		rd = '0;
		case (paddr_i)
			reg_addr(dtc_pkg::IDX_RUN_CTRL): begin
				rd[dtc_pkg::RC_T1_FLAG] = s_r.t1_overflow_flag;
				rd[dtc_pkg::RC_T1_RUN] = s_r.t1_run_bit;
				rd[dtc_pkg::RC_T0_FLAG] = s_r.t0_overflow_flag;
				rd[dtc_pkg::RC_T0_RUN] = s_r.t0_run_bit;
			end
			reg_addr(dtc_pkg::IDX_MODE_SEL): begin
				rd = s_r.timer_mode_reg;
			end
			reg_addr(dtc_pkg::IDX_T0_LOW): begin
				rd = s_r.t0_count_low;
			end
			reg_addr(dtc_pkg::IDX_T0_HIGH): begin
				rd = s_r.t0_count_high;
			end
			reg_addr(dtc_pkg::IDX_T1_LOW): begin
				rd = s_r.t1_count_low;
			end
			reg_addr(dtc_pkg::IDX_T1_HIGH): begin
				rd = s_r.t1_count_high;
			end
			reg_addr(dtc_pkg::IDX_CLK_CTRL): begin
				rd = s_r.timer_clock_ctrl_reg;
			end
			reg_addr(dtc_pkg::IDX_IRQ_STS): begin
				rd = {6'h00, s_r.irq_sts};
			end
			reg_addr(dtc_pkg::IDX_IRQ_MSK): begin
				rd = {6'h00, s_r.irq_msk};
			end
			default: begin
				// unmapped or misaligned: refused with an error, reads zero
				hit = 1'b0;
			end
		endcase
		s_nxt.pready = setup;
		s_nxt.pslverr = setup & ~hit;
		s_nxt.prdata = (setup && !pwrite_i) ? {24'h000000, rd} : '0;

		// a write to a count byte replaces any increment of that cycle
		if (wr) begin
			case (paddr_i)
				reg_addr(dtc_pkg::IDX_MODE_SEL): begin
					s_nxt.timer_mode_reg = wd;
				end
				reg_addr(dtc_pkg::IDX_T0_LOW): begin
					s_nxt.t0_count_low = wd;
				end
				reg_addr(dtc_pkg::IDX_T0_HIGH): begin
					s_nxt.t0_count_high = wd;
				end
				reg_addr(dtc_pkg::IDX_T1_LOW): begin
					s_nxt.t1_count_low = wd;
				end
				reg_addr(dtc_pkg::IDX_T1_HIGH): begin
					s_nxt.t1_count_high = wd;
				end
				reg_addr(dtc_pkg::IDX_CLK_CTRL): begin
					// only the two clock mode bits are kept here
					s_nxt.timer_clock_ctrl_reg = wd & dtc_pkg::CK_WMASK;
				end
				reg_addr(dtc_pkg::IDX_IRQ_MSK): begin
					s_nxt.irq_msk = wd[1:0];
				end
				reg_addr(dtc_pkg::IDX_RUN_CTRL): begin
					s_nxt.t0_run_bit = wd[dtc_pkg::RC_T0_RUN];
					s_nxt.t1_run_bit = wd[dtc_pkg::RC_T1_RUN];
					s_nxt.t0_overflow_flag = wd[dtc_pkg::RC_T0_FLAG];
					s_nxt.t1_overflow_flag = wd[dtc_pkg::RC_T1_FLAG];
				end
				default: begin
				end
			endcase
		end

		// ----------------------------------------------------------------
		// flags and interrupt: a new overflow beats any clear
		// ----------------------------------------------------------------
		if (t0_isr_ack_i) begin
			s_nxt.t0_overflow_flag = 1'b0;
		end
		if (t1_isr_ack_i) begin
			s_nxt.t1_overflow_flag = 1'b0;
		end
		if (ovf0) begin
			s_nxt.t0_overflow_flag = 1'b1;
		end
		if (ovf1) begin
			s_nxt.t1_overflow_flag = 1'b1;
		end
		hit = wr && (paddr_i == reg_addr(dtc_pkg::IDX_IRQ_STS));
		s_nxt.irq_sts = (s_r.irq_sts & ~(hit ? wd[1:0] : 2'h0)) | {ovf1, ovf0};
		s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_msk);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.timer_mode_reg <= dtc_pkg::RST_BYTE;
			s_r.timer_clock_ctrl_reg <= dtc_pkg::RST_BYTE;
			s_r.t0_count_low <= dtc_pkg::RST_BYTE;
			s_r.t0_count_high <= dtc_pkg::RST_BYTE;
			s_r.t1_count_low <= dtc_pkg::RST_BYTE;
			s_r.t1_count_high <= dtc_pkg::RST_BYTE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata_o = s_r.prdata;
	assign pready_o = s_r.pready;
	assign pslverr_o = s_r.pslverr;
	assign irq_o = s_r.irq;

endmodule : dtc_top

`default_nettype wire

// file: test/dtc_checker.sv
// apb answer and read-data checks on dtc_top ports
// assumes bind onto dtc_top
`timescale 1ns/100ps
`default_nettype none
module dtc_checker (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [dtc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [dtc_pkg::DATA_W-1:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	logic hit;
	assign hit = paddr_i[1:0] == 2'h0
		&& (paddr_i[11:2] inside {10'h080, 10'h081, [10'h088:10'h08e]});
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	property p_ready; s_setup |=> pready_o; endproperty
	a_ready: assert property (p_ready) else $error("no answer after setup");
	property p_one; pready_o |=> !pready_o; endproperty
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	property p_err; s_setup ##0 !hit |=> pslverr_o; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_ok; s_setup ##0 hit |=> !pslverr_o; endproperty
	a_ok: assert property (p_ok) else $error("mapped access refused");
	property p_errd; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
	a_errd: assert property (p_errd) else $error("refused access bad data");
	property p_idle; !pready_o |-> prdata_o == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer");
	property p_hi; prdata_o[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_ck; s_setup ##0 paddr_i == 12'h238 |=> (prdata_o & 32'hffffffe7) == 32'h0;
	endproperty
	a_ck: assert property (p_ck) else $error("clock control spare bits set");
endmodule : dtc_checker
bind dtc_top dtc_checker u_chk (.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .paddr_i,
	.prdata_o, .pready_o, .pslverr_o);
`default_nettype wire

// file: test/dtc_pin_model.sv
// board pins: gate levels and falling-edge count pulses
// assumes one-cycle pulse requests from the bench
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_model (
	input wire logic ref_clk_i,
	input wire logic [1:0] pulse_i,
	input wire logic [1:0] gate_i,
	output logic [1:0] gate_pin_o,
	output logic [1:0] cnt_pin_o
);
	logic [1:0][2:0] low_r = '0;
	// pin held low 4 cycles so the 3-ff sampler cannot miss it
	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < 2; i++) begin
			low_r[i] <= pulse_i[i] ? 3'h4 : low_r[i] - 3'(low_r[i] != 3'h0);
		end
	end
	assign cnt_pin_o = {low_r[1] == 3'h0, low_r[0] == 3'h0};
	assign gate_pin_o = gate_i;
endmodule : dtc_pin_model
`default_nettype wire

// file: test/dtc_tb_top.sv
// self-checking bench for dtc_top
// assumes the pin model as board and an apb master here
`timescale 1ns/100ps
`default_nettype none
module dtc_tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] r;
	logic pready, pslverr, irq, e;
	logic [1:0] ack = 2'h0;
	logic [1:0] pulse = 2'h0;
	logic [1:0] gate = 2'h3;
	logic [1:0] gpin, cpin;
	int fails = 0;
	int tests_run = 0;
	typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] x;} dtc_row_t;
	dtc_row_t rows [7] = '{'{12'h224, 8'hff, 8'hff}, '{12'h228, 8'ha5, 8'ha5},
		'{12'h22c, 8'h5a, 8'h5a}, '{12'h230, 8'h3c, 8'h3c}, '{12'h234, 8'hc3, 8'hc3},
		'{12'h238, 8'hff, 8'h18}, '{12'h204, 8'h03, 8'h03}};
	initial forever #20 ref_clk_i = ~ref_clk_i;
	dtc_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(4'hf), .ext_irq0_pin_i(gpin[0]), .ext_irq1_pin_i(gpin[1]),
		.t0_count_pin_i(cpin[0]), .t1_count_pin_i(cpin[1]), .t0_isr_ack_i(ack[0]),
		.t1_isr_ack_i(ack[1]), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .irq_o(irq));
	dtc_pin_model u_pins (.ref_clk_i(ref_clk_i), .pulse_i(pulse), .gate_i(gate),
		.gate_pin_o(gpin), .cnt_pin_o(cpin));
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		n = 0;
		// ready and data are taken at the rising edge, before its updates land
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		if (n >= 50) begin
			fails++;
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(a, 1'b1, {24'h0, d});
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(a, 1'b0, 32'h0);
		cmp(r, {24'h0, x});
	endtask : rd
	task automatic cfg(input logic [7:0] tm, ck, th, tl);
		wr(12'h224, tm);
		wr(12'h238, ck);
		wr(12'h230, th);
		wr(12'h228, tl);
		wr(12'h220, 8'h10);
	endtask : cfg
	task automatic cirq(input logic x);
		@(negedge ref_clk_i);
		cmp({31'h0, irq}, {31'h0, x});
	endtask : cirq
	task automatic pl(input logic [1:0] m);
		@(posedge ref_clk_i);
		pulse <= m;
		@(posedge ref_clk_i);
		pulse <= 2'h0;
		repeat (8) @(posedge ref_clk_i);
	endtask : pl
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		fails++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a, 8'h00);
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].x);
		end
		apb(12'h3fc, 1'b0, 32'h0);
		cmp({31'h0, e}, 32'h1);
		// ---------------------------------------------
		// overflow, flag, interrupt, hold
		// ---------------------------------------------
		cfg(8'h01, 8'h08, 8'hff, 8'hff);
		rd(12'h200, 8'h01);
		cirq(1'b1);
		rd(12'h220, 8'h30);
		wr(12'h220, 8'h20);
		wr(12'h228, 8'h77);
		repeat (30) @(posedge ref_clk_i);
		rd(12'h228, 8'h77);
		wr(12'h204, 8'h00);
		cirq(1'b0);
		wr(12'h204, 8'h01);
		cirq(1'b1);
		wr(12'h200, 8'h01);
		cirq(1'b0);
		@(posedge ref_clk_i);
		ack <= 2'h1;
		@(posedge ref_clk_i);
		ack <= 2'h0;
		rd(12'h220, 8'h00);
		// ---------------------------------------------
		// modes and clock paths
		// ---------------------------------------------
		cfg(8'h00, 8'h08, 8'h00, 8'hfe);
		repeat (8) @(posedge ref_clk_i);
		wr(12'h220, 8'h00);
		rd(12'h230, 8'h01);
		apb(12'h228, 1'b0, 32'h0);
		cmp(r & 32'he0, 32'he0);
		cfg(8'h01, 8'h00, 8'h00, 8'h00);
		repeat (120) @(posedge ref_clk_i);
		wr(12'h220, 8'h00);
		apb(12'h228, 1'b0, 32'h0);
		cmp({31'h0, r >= 32'h8 && r <= 32'hc}, 32'h1);
		cfg(8'h02, 8'h08, 8'hf0, 8'hf0);
		repeat (40) @(posedge ref_clk_i);
		wr(12'h220, 8'h00);
		rd(12'h230, 8'hf0);
		apb(12'h228, 1'b0, 32'h0);
		cmp({31'h0, r >= 32'hf0}, 32'h1);
		rd(12'h200, 8'h01);
		// ---------------------------------------------
		// count pin and gate
		// ---------------------------------------------
		cfg(8'h04, 8'h00, 8'h00, 8'h00);
		repeat (3) pl(2'h1);
		rd(12'h228, 8'h03);
		wr(12'h224, 8'h0c);
		gate <= 2'h2;
		repeat (2) pl(2'h1);
		rd(12'h228, 8'h03);
		gate <= 2'h3;
		repeat (2) pl(2'h1);
		rd(12'h228, 8'h05);
		// ---------------------------------------------
		// timer 1: pin, gate, halt, reload, split
		// ---------------------------------------------
		wr(12'h22c, 8'h00);
		wr(12'h234, 8'h00);
		wr(12'h224, 8'h40);
		wr(12'h220, 8'h40);
		repeat (2) pl(2'h2);
		rd(12'h22c, 8'h02);
		wr(12'h224, 8'hc0);
		gate <= 2'h1;
		repeat (2) pl(2'h2);
		rd(12'h22c, 8'h02);
		gate <= 2'h3;
		pl(2'h2);
		rd(12'h22c, 8'h03);
		wr(12'h238, 8'h10);
		wr(12'h224, 8'h30);
		repeat (20) @(posedge ref_clk_i);
		rd(12'h22c, 8'h03);
		wr(12'h234, 8'hf0);
		wr(12'h22c, 8'hf0);
		wr(12'h224, 8'h20);
		repeat (40) @(posedge ref_clk_i);
		wr(12'h220, 8'h00);
		rd(12'h234, 8'hf0);
		apb(12'h22c, 1'b0, 32'h0);
		cmp({31'h0, r >= 32'hf0}, 32'h1);
		rd(12'h200, 8'h03);
		wr(12'h200, 8'h03);
		wr(12'h238, 8'h08);
		wr(12'h224, 8'h03);
		wr(12'h230, 8'hfe);
		wr(12'h228, 8'h33);
		wr(12'h220, 8'h40);
		repeat (10) @(posedge ref_clk_i);
		rd(12'h200, 8'h02);
		rd(12'h220, 8'hc0);
		rd(12'h228, 8'h33);
		// ---------------------------------------------
		// reset in mid-run
		// ---------------------------------------------
		@(posedge ref_clk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rd(12'h224, 8'h00);
		rd(12'h238, 8'h00);
		rd(12'h230, 8'h00);
		rd(12'h234, 8'h00);
		rd(12'h200, 8'h00);
		cirq(1'b0);
		final_report();
	end
endmodule : dtc_tb_top
`default_nettype wire
